// ==== hdl/i2c_collision_pkg.sv ====
package i2c_collision_pkg;

	// register byte addresses on the bus
	localparam logic [7:0] ADDR_INT_EN_ONE   = 8'h00;
	localparam logic [7:0] ADDR_INT_EN_TWO   = 8'h04;
	localparam logic [7:0] ADDR_INT_FLAGS_ONE = 8'h08;
	localparam logic [7:0] ADDR_INT_FLAGS_TWO = 8'h0c;
	localparam logic [7:0] ADDR_BAUD_RELOAD  = 8'h10;
	localparam logic [7:0] ADDR_DATA_BUFFER  = 8'h14;
	localparam logic [7:0] ADDR_CONTROL_ONE  = 8'h18;
	localparam logic [7:0] ADDR_CONTROL_TWO  = 8'h1c;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h20;
	localparam logic [7:0] ADDR_ADDRESS_MASK = 8'h24;
	localparam logic [7:0] ADDR_STATUS       = 8'h28;

	// field positions
	localparam int PORT_EVENT_BIT    = 3;
	localparam int BUS_COLLISION_BIT = 3;
	localparam int START_BIT         = 0;
	localparam int RESTART_BIT       = 1;
	localparam int STOP_BIT          = 2;
	localparam int STATUS_STOP_BIT   = 4;
	localparam int STATUS_START_BIT  = 3;

	// reset values
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [7:0] RESET_RELOAD = 8'h13;

	// bus clock = hclk / ((reload + 1) * 2); CLOCK_DIVISOR is unused
	localparam int CLOCK_DIVISOR = 4;

	typedef enum {
		ST_IDLE,
		ST_START_HOLD,
		ST_START_LOW,
		ST_RS_RELEASE,
		ST_RS_SCL_WAIT,
		ST_RS_HOLD,
		ST_RS_LOW,
		ST_STOP_SDA,
		ST_STOP_SCL_WAIT,
		ST_STOP_HOLD,
		ST_STOP_CHECK,
		ST_WATCH
	} cond_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_t;

	typedef struct packed {
		logic       sel;
		logic       write;
		logic [7:0] addr;
	} ahb_phase_t;

	typedef struct packed {
		cond_state_t state;
		ahb_phase_t  phase;
		logic [7:0]  int_en_one;
		logic [7:0]  int_en_two;
		logic        port_event_flag;
		logic        bus_collision_flag;
		logic [7:0]  baud_reload_value;
		logic [7:0]  serial_data_buffer;
		logic [7:0]  control_one;
		logic [7:0]  control_two;
		logic [7:0]  control_three;
		logic [7:0]  address_mask;
		logic        stop_seen;
		logic        start_seen;
		logic [7:0]  baud_counter;
		logic        counting;
		logic        sda_low;
		logic        scl_low;
		bus_lines_t  sync1;
		bus_lines_t  sync2;
		bus_lines_t  sync3;
		bus_lines_t  line;
		logic [31:0] rdata;
	} state_t;

endpackage

// ==== hdl/i2c_master_collision_brg.sv ====
`timescale 1ns/10ps
// Behaviour
// R1: start with either line already low aborts, flags collision, goes to watch state
// R2: clock low while data still released during start flags collision
// R3: start begins released; data high loads and runs baud counter
// R4: data low during first start count resets counter, drives data low now
// R5: data high through first count: drive data low, reload, then clock low
// R6: clock low during second start count is not a collision
// R7: restart releases data, counts, releases clock; data low at clock high collides
// R8: restart reloads counter; data falling before expiry is not a collision
// R9: restart clock falling before expiry with data undriven flags collision
// R10: restart both high at expiry: data low, reload, then clock low always
// R11: stop drives data low, releases clock, counts, then checks data high
// R12: stop clock low before data released flags collision
// R13: baud counter reloads from register and starts on buffer write
// R14: operation end stops the counter and holds clock at its last level
// R15: reload twice per bus clock period: rate is hclk/((reload+1)*2)
// R16: software must not load reload values 0x00, 0x01 or 0x02
// R17: any collision aborts the condition, releases lines, clears its request
// R18: after a collision, a bus stop condition sets the port event flag
// R19: collision flag is sticky until cleared and interrupts when enabled
module i2c_master_collision_brg (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             irq
);
	import i2c_collision_pkg::*;

	state_t r_reg;
	state_t r_next;

	logic       wr_en;
	logic       rd_en;
	logic       expired;
	logic       collide;
	logic [7:0] wbyte;
	logic [7:0] status_byte;
	logic [7:0] flags_one;
	logic [7:0] flags_two;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = r_reg.rdata;
	assign scl_out   = 1'b0;
	assign sda_out   = 1'b0;
	assign scl_oe    = r_reg.scl_low;
	assign sda_oe    = r_reg.sda_low;
	assign irq       = (r_reg.port_event_flag & r_reg.int_en_one[PORT_EVENT_BIT])
		| (r_reg.bus_collision_flag
		& r_reg.int_en_two[BUS_COLLISION_BIT]); // R19

	assign wr_en   = r_reg.phase.sel & r_reg.phase.write;
	assign rd_en   = hsel & hready & htrans[1] & ~hwrite;
	assign wbyte   = hwdata[7:0];
	assign expired = r_reg.counting && (r_reg.baud_counter == 8'h00);

	always_comb begin
		flags_one = 8'h00;
		flags_one[PORT_EVENT_BIT] = r_reg.port_event_flag;
		flags_two = 8'h00;
		flags_two[BUS_COLLISION_BIT] = r_reg.bus_collision_flag;
		status_byte = 8'h00;
		status_byte[STATUS_STOP_BIT]  = r_reg.stop_seen;
		status_byte[STATUS_START_BIT] = r_reg.start_seen;
	end

	always_comb begin
		r_next = r_reg;
		collide = 1'b0;

		// three-stage pin synchroniser, change taken when stages 2 and 3 agree
		r_next.sync1.scl = scl_in;
		r_next.sync1.sda = sda_in;
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		if (r_reg.sync2.scl == r_reg.sync3.scl) begin
			r_next.line.scl = r_reg.sync3.scl;
		end
		if (r_reg.sync2.sda == r_reg.sync3.sda) begin
			r_next.line.sda = r_reg.sync3.sda;
		end

		// bus start/stop detection
		if (r_reg.line.scl && r_next.line.scl) begin
			if (r_reg.line.sda && !r_next.line.sda) begin
				r_next.start_seen = 1'b1;
				r_next.stop_seen  = 1'b0;
			end else if (!r_reg.line.sda && r_next.line.sda) begin
				r_next.stop_seen  = 1'b1;
				r_next.start_seen = 1'b0;
			end
		end

		// baud counter: reload each expiry, twice per bus clock
		if (r_reg.counting) begin
			if (expired) begin
				r_next.baud_counter = r_reg.baud_reload_value; // R15
			end else begin
				r_next.baud_counter = r_reg.baud_counter - 8'h01;
			end
		end

		// register read, sampled in address phase, presented in data phase
		r_next.phase.sel   = hsel & hready & htrans[1];
		r_next.phase.write = hwrite;
		r_next.phase.addr  = haddr[7:0];
		if (hsel & hready & htrans[1]) begin
			r_next.rdata = 32'h0000_0000;
		end
		if (rd_en) begin
			case (haddr[7:0])
			ADDR_INT_EN_ONE:    r_next.rdata[7:0] = r_reg.int_en_one;
			ADDR_INT_EN_TWO:    r_next.rdata[7:0] = r_reg.int_en_two;
			ADDR_INT_FLAGS_ONE: r_next.rdata[7:0] = flags_one;
			ADDR_INT_FLAGS_TWO: r_next.rdata[7:0] = flags_two;
			ADDR_BAUD_RELOAD:   r_next.rdata[7:0] = r_reg.baud_reload_value;
			ADDR_DATA_BUFFER:   r_next.rdata[7:0] = r_reg.serial_data_buffer;
			ADDR_CONTROL_ONE:   r_next.rdata[7:0] = r_reg.control_one;
			ADDR_CONTROL_TWO:   r_next.rdata[7:0] = r_reg.control_two;
			ADDR_CONTROL_THREE: r_next.rdata[7:0] = r_reg.control_three;
			ADDR_ADDRESS_MASK:  r_next.rdata[7:0] = r_reg.address_mask;
			ADDR_STATUS:        r_next.rdata[7:0] = status_byte;
			default:            r_next.rdata = 32'h0000_0000;
			endcase
		end

		// reading a flag register clears its sticky flag, a set below wins
		if (rd_en && haddr[7:0] == ADDR_INT_FLAGS_ONE) begin
			r_next.port_event_flag = 1'b0;
		end
		if (rd_en && haddr[7:0] == ADDR_INT_FLAGS_TWO) begin
			r_next.bus_collision_flag = 1'b0; // R19
		end

		// register write in data phase
		if (wr_en) begin
			case (r_reg.phase.addr)
			ADDR_INT_EN_ONE:    r_next.int_en_one = wbyte;
			ADDR_INT_EN_TWO:    r_next.int_en_two = wbyte;
			ADDR_INT_FLAGS_ONE: r_next.port_event_flag = wbyte[PORT_EVENT_BIT];
			ADDR_INT_FLAGS_TWO:
				r_next.bus_collision_flag = wbyte[BUS_COLLISION_BIT]; // R19
			ADDR_BAUD_RELOAD:   r_next.baud_reload_value = wbyte; // R16
			ADDR_DATA_BUFFER: begin
				r_next.serial_data_buffer = wbyte;
				r_next.baud_counter = r_reg.baud_reload_value; // R13
				r_next.counting = 1'b1; // R13
			end
			ADDR_CONTROL_ONE:   r_next.control_one = wbyte;
			ADDR_CONTROL_TWO:   r_next.control_two = wbyte;
			ADDR_CONTROL_THREE: r_next.control_three = wbyte;
			ADDR_ADDRESS_MASK:  r_next.address_mask = wbyte;
			default: begin
			end
			endcase
		end

		// condition sequencer
		case (r_reg.state)
		ST_IDLE, ST_WATCH: begin
			if (r_reg.state == ST_WATCH && r_next.stop_seen
				&& !r_reg.stop_seen) begin
				r_next.port_event_flag = 1'b1; // R18
				r_next.state = ST_IDLE;
			end
			if (r_next.control_two[START_BIT]) begin
				r_next.sda_low = 1'b0; // R3
				r_next.scl_low = 1'b0; // R3
				if (!r_reg.line.sda || !r_reg.line.scl) begin
					collide = 1'b1; // R1
				end else begin
					r_next.baud_counter = r_reg.baud_reload_value; // R3
					r_next.counting = 1'b1; // R3
					r_next.state = ST_START_HOLD;
				end
			end else if (r_next.control_two[RESTART_BIT]) begin
				r_next.sda_low = 1'b0; // R7
				r_next.counting = 1'b0; // R7
				r_next.state = ST_RS_RELEASE;
			end else if (r_next.control_two[STOP_BIT]) begin
				r_next.sda_low = 1'b1; // R11
				r_next.state = ST_STOP_SDA;
			end
		end
		ST_START_HOLD: begin
			if (!r_reg.line.scl && r_reg.line.sda) begin
				collide = 1'b1; // R2
			end else if (!r_reg.line.sda || expired) begin
				r_next.sda_low = 1'b1; // R4 R5
				r_next.baud_counter = r_reg.baud_reload_value; // R4 R5
				r_next.counting = 1'b1;
				r_next.state = ST_START_LOW;
			end
		end
		ST_START_LOW: begin
			// clock low here is ignored
			if (expired) begin // R6
				r_next.scl_low = 1'b1; // R5
				r_next.counting = 1'b0; // R14
				r_next.control_two[START_BIT] = 1'b0;
				r_next.port_event_flag = 1'b1;
				r_next.state = ST_IDLE;
			end
		end
		ST_RS_RELEASE: begin
			if (r_reg.line.sda && !r_reg.counting) begin
				r_next.baud_counter = r_reg.baud_reload_value; // R7
				r_next.counting = 1'b1;
			end else if (expired) begin
				r_next.scl_low = 1'b0; // R7
				r_next.counting = 1'b0;
				r_next.state = ST_RS_SCL_WAIT;
			end
		end
		ST_RS_SCL_WAIT: begin
			if (r_reg.line.scl) begin
				if (!r_reg.line.sda) begin
					collide = 1'b1; // R7
				end else begin
					r_next.baud_counter = r_reg.baud_reload_value; // R8
					r_next.counting = 1'b1;
					r_next.state = ST_RS_HOLD;
				end
			end
		end
		ST_RS_HOLD: begin
			if (!r_reg.line.scl) begin
				collide = 1'b1; // R9
			end else if (expired) begin
				// data falling before here is ignored
				r_next.sda_low = 1'b1; // R8 R10
				r_next.baud_counter = r_reg.baud_reload_value; // R10
				r_next.state = ST_RS_LOW;
			end
		end
		ST_RS_LOW: begin
			if (expired) begin
				r_next.scl_low = 1'b1; // R10
				r_next.counting = 1'b0; // R14
				r_next.control_two[RESTART_BIT] = 1'b0;
				r_next.port_event_flag = 1'b1;
				r_next.state = ST_IDLE;
			end
		end
		ST_STOP_SDA: begin
			if (!r_reg.line.sda) begin
				r_next.scl_low = 1'b0; // R11
				r_next.state = ST_STOP_SCL_WAIT;
			end
		end
		ST_STOP_SCL_WAIT: begin
			if (r_reg.line.scl) begin
				r_next.baud_counter = r_reg.baud_reload_value; // R11
				r_next.counting = 1'b1;
				r_next.state = ST_STOP_HOLD;
			end
		end
		ST_STOP_HOLD: begin
			if (!r_reg.line.scl) begin
				collide = 1'b1; // R12
			end else if (expired) begin
				r_next.sda_low = 1'b0; // R11
				r_next.state = ST_STOP_CHECK;
			end
		end
		ST_STOP_CHECK: begin
			if (expired) begin
				r_next.counting = 1'b0; // R14
				if (!r_reg.line.sda) begin
					collide = 1'b1; // R11
				end else begin
					r_next.control_two[STOP_BIT] = 1'b0;
					r_next.port_event_flag = 1'b1;
					r_next.state = ST_IDLE;
				end
			end
		end
		default: r_next.state = ST_IDLE;
		endcase

		if (collide) begin
			r_next.bus_collision_flag = 1'b1; // R19
			r_next.sda_low = 1'b0; // R17
			r_next.scl_low = 1'b0; // R17
			r_next.counting = 1'b0;
			r_next.control_two[START_BIT]   = 1'b0; // R17
			r_next.control_two[RESTART_BIT] = 1'b0; // R17
			r_next.control_two[STOP_BIT]    = 1'b0; // R17
			r_next.state = ST_WATCH; // R18
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
			r_reg.state <= ST_IDLE;
			r_reg.baud_reload_value <= RESET_RELOAD;
			r_reg.sync1 <= 2'b11;
			r_reg.sync2 <= 2'b11;
			r_reg.sync3 <= 2'b11;
			r_reg.line  <= 2'b11;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

// ==== verif/i2c_master_collision_brg_properties.sv ====
`timescale 1ns/10ps
module i2c_master_collision_brg_properties (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        scl_in,
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        irq
);
	import i2c_collision_pkg::*;
	logic       ap_wr;
	logic [7:0] ap_adr;
	logic [3:0] low_cnt;
	logic       start_wr;
	assign start_wr = ap_wr && ap_adr == ADDR_CONTROL_TWO && hwdata[START_BIT];
	// write data phase tracking and data-low time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr <= 1'b0;
			ap_adr <= 8'h00;
			low_cnt <= 4'h0;
		end else begin
			ap_wr <= hsel && hready && htrans[1] && hwrite;
			ap_adr <= haddr[7:0];
			low_cnt <= sda_in ? 4'h0 : (low_cnt == 4'hf ? low_cnt : low_cnt + 4'h1);
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_always_a: assert property (hreadyout)
		else $error("hreadyout low");
	resp_okay_a: assert property (!hresp)
		else $error("error response");
	drive_low_only_a: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	rdata_byte_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	rdata_hold_a: assert property (!$past(hsel && hready && htrans[1]) |-> $stable(hrdata))
		else $error("read data changed without transfer");
	scl_after_sda_a: assert property ($rose(scl_oe) |-> $past(sda_oe, 3))
		else $error("clock pulled before data held");
	busy_start_abort_a: assert property (start_wr && low_cnt >= 4'h8 && !sda_oe && !scl_oe |=> !sda_oe [*8])
		else $error("start on busy bus drove data");
	irq_clear_cause_a: assert property ($fell(irq) |->
		$past(hsel && hready && htrans[1])
		|| $past(hsel && hready && htrans[1], 2))
		else $error("irq dropped without register access");
endmodule

// ==== verif/bus_peer.sv ====
`timescale 1ns/10ps
module bus_peer (
	input  wire logic       hclk,
	input  wire logic       scl_oe,
	input  wire logic       sda_oe,
	input  wire logic       pull_scl,
	input  wire logic       pull_sda,
	input  wire logic [3:0] stretch,
	output logic            scl_line,
	output logic            sda_line
);
	logic [3:0] hold_cnt;
	logic       scl_d;
	initial begin
		hold_cnt = 4'h0;
		scl_d = 1'b0;
	end
	// a slow slave keeps the clock low a while after the master lets go
	always @(posedge hclk) begin
		scl_d <= scl_oe;
		if (scl_d && !scl_oe)
			hold_cnt <= stretch;
		else if (hold_cnt != 4'h0)
			hold_cnt <= hold_cnt - 4'h1;
	end
	// pulled-up lines, low while any party pulls
	assign scl_line = !(scl_oe || pull_scl || hold_cnt != 4'h0);
	assign sda_line = !(sda_oe || pull_sda);
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	import i2c_collision_pkg::*;
	localparam logic [7:0] RLD = 8'h08;
	logic        hclk, hresetn, hsel, hwrite, rd_ph, pull_scl, pull_sda;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic        hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, irq;
	logic        scl_line, sda_line;
	logic [3:0]  stretch;
	logic [7:0]  exp_q[$], adr_q[$], d;
	int          err_count, checks_done, seed, n;
	i2c_master_collision_brg dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	bus_peer peer (.hclk(hclk), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.pull_scl(pull_scl), .pull_sda(pull_sda), .stretch(stretch),
		.scl_line(scl_line), .sda_line(sda_line));
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [7:0] v);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, v};
		rd_ph <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		adr_q.push_back(a);
		ahb(1'b0, a, 8'h00);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task wait_oe(input logic sel, output int c);
		c = 0;
		while ((sel ? scl_oe : sda_oe) !== 1'b1 && c < 300) begin
			@(posedge hclk);
			c++;
		end
		chk("oe wait", 8'h01, {7'h0, c < 300});
	endtask
	task stop_seq;
		ahb(1'b1, ADDR_CONTROL_TWO, 8'h04);
		cyc(60);
		rd(ADDR_CONTROL_TWO, 8'h00);
		rd(ADDR_INT_FLAGS_ONE, 8'h08);
		chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
		ahb(1'b1, ADDR_INT_FLAGS_ONE, 8'h00);
	endtask
	// read results, oldest note first
	always @(posedge hclk)
		if (rd_ph === 1'b1 && hreadyout === 1'b1)
			chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), hrdata[7:0]);
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		complete_run;
	end
	initial begin
		seed = 38;
		{hsel, hwrite, rd_ph, pull_scl, pull_sda} = 5'h0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		stretch = 4'h0;
		err_count = 0;
		checks_done = 0;
		hresetn = 1'b0;
		cyc(16);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ADDR_BAUD_RELOAD, RESET_RELOAD);
		rd(ADDR_CONTROL_TWO, RESET_BYTE);
		rd(ADDR_INT_FLAGS_TWO, RESET_BYTE);
		rd(8'h2c, 8'h00);
		d = 8'($random(seed));
		ahb(1'b1, ADDR_ADDRESS_MASK, d);
		rd(ADDR_ADDRESS_MASK, d);
		ahb(1'b1, ADDR_BAUD_RELOAD, RLD);
		ahb(1'b1, ADDR_INT_EN_ONE, 8'h08);
		ahb(1'b1, ADDR_INT_EN_TWO, 8'h08);
		$display("test registers done");
		stretch <= 4'h3;
		ahb(1'b1, ADDR_CONTROL_TWO, 8'h01);
		wait_oe(1'b0, n);
		pull_scl <= 1'b1;
		wait_oe(1'b1, n);
		pull_scl <= 1'b0;
		chk("start delay", RLD + 8'h01, n[7:0]);
		cyc(4);
		rd(ADDR_CONTROL_TWO, 8'h00);
		rd(ADDR_INT_FLAGS_TWO, 8'h00);
		chk("irq", 8'h01, {7'h0, irq});
		ahb(1'b1, ADDR_INT_FLAGS_ONE, 8'h00);
		ahb(1'b1, ADDR_CONTROL_TWO, 8'h02);
		cyc(60);
		rd(ADDR_CONTROL_TWO, 8'h00);
		rd(ADDR_INT_FLAGS_TWO, 8'h00);
		chk("lines", 8'h03, {6'h0, scl_oe, sda_oe});
		ahb(1'b1, ADDR_INT_FLAGS_ONE, 8'h00);
		stop_seq;
		$display("test conditions done");
		ahb(1'b1, ADDR_CONTROL_TWO, 8'h01);
		cyc(2);
		pull_sda <= 1'b1;
		wait_oe(1'b0, n);
		chk("early data", 8'h01, {7'h0, n < RLD});
		wait_oe(1'b1, n);
		pull_sda <= 1'b0;
		rd(ADDR_INT_FLAGS_TWO, 8'h00);
		ahb(1'b1, ADDR_INT_FLAGS_ONE, 8'h00);
		stop_seq;
		$display("test early start done");
		ahb(1'b1, ADDR_INT_EN_TWO, 8'h00);
		pull_sda <= 1'b1;
		cyc(10);
		ahb(1'b1, ADDR_CONTROL_TWO, 8'h01);
		cyc(20);
		chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
		rd(ADDR_CONTROL_TWO, 8'h00);
		chk("masked irq", 8'h00, {7'h0, irq});
		ahb(1'b1, ADDR_INT_EN_TWO, 8'h08);
		cyc(2);
		chk("irq", 8'h01, {7'h0, irq});
		rd(ADDR_INT_FLAGS_TWO, 8'h08);
		chk("irq read clear", 8'h00, {7'h0, irq});
		rd(ADDR_INT_FLAGS_TWO, 8'h00);
		pull_sda <= 1'b0;
		cyc(10);
		rd(ADDR_INT_FLAGS_ONE, 8'h08);
		rd(ADDR_INT_FLAGS_ONE, 8'h00);
		ahb(1'b1, ADDR_INT_FLAGS_TWO, 8'h00);
		ahb(1'b1, ADDR_INT_FLAGS_ONE, 8'h00);
		cyc(2);
		chk("irq", 8'h00, {7'h0, irq});
		$display("test busy start done");
		ahb(1'b1, ADDR_CONTROL_TWO, 8'h01);
		cyc(2);
		pull_scl <= 1'b1;
		cyc(20);
		pull_scl <= 1'b0;
		rd(ADDR_INT_FLAGS_TWO, 8'h08);
		chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
		$display("test clock collision done");
		cyc(2);
		complete_run;
	end
endmodule
bind i2c_master_collision_brg i2c_master_collision_brg_properties props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
	.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
